// file: hdl/pmsr_defs.vh
`ifndef PMSR_DEFS_VH
`define PMSR_DEFS_VH

// register offsets
`define PMSR_A_CTRL 4'h0
`define PMSR_A_MODE 4'h1
`define PMSR_A_WAKE_EN 4'h2
`define PMSR_A_SRAM_CFG 4'h3
`define PMSR_A_RET_CFG 4'h4
`define PMSR_A_STATUS 4'h5
`define PMSR_A_MASK 4'h6
`define PMSR_A_INFO 4'h7

// power modes
`define PMSR_M_ACTIVE 2'h0
`define PMSR_M_CORE_GATED 2'h1
`define PMSR_M_HIBERNATE 2'h2
`define PMSR_M_SHUTDOWN 2'h3

// wake enable / status bit positions
`define PMSR_W_EXT0 0
`define PMSR_W_EXT1 1
`define PMSR_W_EXT2 2
`define PMSR_W_SER_RX 3
`define PMSR_W_PRI_RTC 4
`define PMSR_W_SEC_RTC 5

// status extra bits
`define PMSR_S_WOKE 6
`define PMSR_S_PAR_ERR 7

// sram config bits
`define PMSR_C_INSTR_EN 0
`define PMSR_C_CACHE_EN 1
`define PMSR_C_PARITY_EN 2

// retention config bits
`define PMSR_R_INSTR16 0
`define PMSR_R_DATA8 1

// reset values
`define PMSR_RST_WAKE_EN 8'h0F
`define PMSR_RST_SRAM_CFG 8'h01
`define PMSR_RST_RET_CFG 8'h00

// sizes in KB
`define PMSR_BANK_KB 8'h20
`define PMSR_CACHE_KB 8'h04
`define PMSR_RET_STEP_KB 8'h08
`define PMSR_RET_INSTR_KB 8'h10

// power sequencing times, ns
`define PMSR_T_PWR_NS 2000
`define PMSR_T_CLK_NS 500
`define PMSR_CLK_NS 100

`endif

// file: hdl/pmsr_sync.v
`timescale 1ns/100ps
module pmsr_sync #(
	parameter W = 8
) (
	// clock and reset
	input wire sys_clk_i,
	input wire rst_i,
	// data
	input wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;

always @(posedge sys_clk_i or posedge rst_i) begin
	if (rst_i) begin
		meta_q <= {W{1'b0}};
		sync_q <= {W{1'b0}};
	end else begin
		meta_q <= async_i;
		sync_q <= meta_q;
	end
end

assign sync_o = sync_q;

endmodule

// file: hdl/pmsr_top.v
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`include "pmsr_defs.vh"
module pmsr_top #(
	parameter PWR_CYC = (`PMSR_T_PWR_NS + `PMSR_CLK_NS - 1) / `PMSR_CLK_NS,
	parameter CLK_CYC = (`PMSR_T_CLK_NS + `PMSR_CLK_NS - 1) / `PMSR_CLK_NS
) (
	// clock and reset
	input wire sys_clk_i,
	input wire rst_i,
	// register port
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// wake sources, asynchronous
	input wire [2:0] ext_wake_irq_i,
	input wire serial_rx_wake_i,
	input wire primary_rt_counter_i,
	input wire secondary_rt_counter_i,
	// core side
	input wire core_sleep_i,
	input wire sram_parity_err_i,
	output wire core_clk_en_o,
	output wire core_run_o,
	output wire dma_clk_en_o,
	output wire periph_clk_en_o,
	// power gating
	output wire digital_pwr_en_o,
	output wire analog_pwr_en_o,
	output wire logic_retain_o,
	output wire pin_out_hold_o,
	output wire pin_cfg_retain_o,
	output wire pri_rtc_pwr_en_o,
	output wire sec_rtc_pwr_en_o,
	// sram configuration
	output wire [3:0] sram_ret_bank_o,
	output wire [7:0] sram_ret_kb_o,
	output wire [7:0] data_sram_kb_o,
	output wire [7:0] instr_sram_kb_o,
	output wire cache_alloc_o,
	output wire parity_en_o,
	output wire [1:0] sram_wait_o,
	output wire [2:0] access_size_mask_o,
	// current mode and interrupt
	output wire [1:0] mode_o,
	output wire irq_o
);

////////////////////////////////////////////////////////////////
localparam ST_ACTIVE = 3'h0;
localparam ST_CGATED = 3'h1;
localparam ST_DOWN = 3'h2;
localparam ST_SLEEP = 3'h3;
localparam ST_PWR_UP = 3'h4;
localparam ST_CLK_UP = 3'h5;

reg [2:0] st_q, st_d;
reg [1:0] mode_q, mode_d;
reg [1:0] req_mode_q;
reg go_q;
reg [7:0] wake_en_q;
reg [7:0] sram_cfg_q;
reg [7:0] ret_cfg_q;
reg [7:0] status_q;
reg [7:0] mask_q;
reg [15:0] cnt_q, cnt_d;
reg [5:0] wake_prev_q;
wire [5:0] wake_raw;
wire [5:0] wake_s;
wire [5:0] wake_rise;
wire [5:0] wake_allow;
wire wake_hit;
wire par_s;
reg par_prev_q;

// every wake request passes two flops
pmsr_sync #(.W(7)) u_sync (
	.sys_clk_i(sys_clk_i),
	.rst_i(rst_i),
	.async_i({sram_parity_err_i, secondary_rt_counter_i, primary_rt_counter_i,
		serial_rx_wake_i, ext_wake_irq_i}),
	.sync_o({par_s, wake_s})
);

assign wake_raw = wake_s;

// one edge detector per source, so status shows which line woke us from hibernate or shutdown
genvar g;
generate
	for (g = 0; g < 6; g = g + 1) begin : g_rise
		assign wake_rise[g] = wake_s[g] & ~wake_prev_q[g];
	end
endgenerate

// legal wake sources per sleep mode
function [5:0] allowed;
	input [1:0] m;
	begin
		allowed = 6'h00;
		case (m)
			`PMSR_M_HIBERNATE: allowed = 6'h3F;
			// serial and secondary counter are unpowered in shutdown
			`PMSR_M_SHUTDOWN: begin
				allowed[`PMSR_W_EXT0] = 1'b1;
				allowed[`PMSR_W_EXT1] = 1'b1;
				allowed[`PMSR_W_EXT2] = 1'b1;
				allowed[`PMSR_W_PRI_RTC] = 1'b1;
			end
			default: allowed = 6'h00;
		endcase
	end
endfunction

// shutdown: three ext plus primary counter
assign wake_allow = allowed(mode_q) & wake_en_q[5:0];
assign wake_hit = |(wake_raw & wake_allow);

////////////////////////////////////////////////////////////////
// register writes
// register write decode
function wr_hit;
	input we;
	input [3:0] a;
	input [3:0] sel;
	begin
		wr_hit = we && (a == sel);
	end
endfunction

wire wr_ctrl = wr_hit(reg_wr_i, reg_addr_i, `PMSR_A_CTRL);
wire [7:0] ev_set;
reg woke_ev;

assign ev_set = {par_s & ~par_prev_q, woke_ev, wake_rise & wake_allow};

always @(posedge sys_clk_i or posedge rst_i) begin
	if (rst_i) begin
		wake_en_q <= `PMSR_RST_WAKE_EN;
		sram_cfg_q <= `PMSR_RST_SRAM_CFG;
		ret_cfg_q <= `PMSR_RST_RET_CFG;
		mask_q <= 8'h00;
		status_q <= 8'h00;
		req_mode_q <= `PMSR_M_ACTIVE;
		go_q <= 1'b0;
		wake_prev_q <= 6'h00;
		par_prev_q <= 1'b0;
	end else begin
		wake_prev_q <= wake_s;
		par_prev_q <= par_s;
		go_q <= wr_ctrl && reg_wdata_i[0];
		if (wr_ctrl)
			req_mode_q <= reg_wdata_i[2:1];
		if (wr_hit(reg_wr_i, reg_addr_i, `PMSR_A_WAKE_EN))
			wake_en_q <= reg_wdata_i & 8'h3F;
		if (wr_hit(reg_wr_i, reg_addr_i, `PMSR_A_SRAM_CFG) && st_q == ST_ACTIVE)
			sram_cfg_q <= reg_wdata_i & 8'h07;
		if (wr_hit(reg_wr_i, reg_addr_i, `PMSR_A_RET_CFG))
			ret_cfg_q <= reg_wdata_i & 8'h03;
		if (wr_hit(reg_wr_i, reg_addr_i, `PMSR_A_MASK))
			mask_q <= reg_wdata_i;
		// set wins over write-one clear
		if (wr_hit(reg_wr_i, reg_addr_i, `PMSR_A_STATUS))
			status_q <= (status_q & ~reg_wdata_i) | ev_set;
		else
			status_q <= status_q | ev_set;
		if (st_q == ST_DOWN && mode_q == `PMSR_M_SHUTDOWN) begin
			sram_cfg_q <= `PMSR_RST_SRAM_CFG;
			ret_cfg_q <= `PMSR_RST_RET_CFG;
			mask_q <= 8'h00;
		end
	end
end

////////////////////////////////////////////////////////////////
// mode sequencer
always @* begin
	st_d = st_q;
	mode_d = mode_q;
	cnt_d = (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : 16'h0000;
	woke_ev = 1'b0;
	case (st_q)
		ST_ACTIVE: begin
			if (go_q && core_sleep_i) begin
				mode_d = req_mode_q;
				if (req_mode_q == `PMSR_M_CORE_GATED)
					st_d = ST_CGATED;
				else if (req_mode_q != `PMSR_M_ACTIVE) begin
					st_d = ST_DOWN;
					cnt_d = CLK_CYC[15:0];
				end
			end
		end
		// DMA runs, core stalled until wake
		ST_CGATED: begin
			if (|wake_raw) begin
				st_d = ST_ACTIVE;
				mode_d = `PMSR_M_ACTIVE;
			end
		end
		// clocks stop before power is cut
		ST_DOWN: begin
			if (cnt_q == 16'h0000)
				st_d = ST_SLEEP;
		end
		ST_SLEEP: begin
			if (wake_hit) begin
				st_d = ST_PWR_UP;
				cnt_d = PWR_CYC[15:0];
			end
		end
		// power first, then a clock settle wait, then clocks and core together
		ST_PWR_UP: begin
			if (cnt_q == 16'h0000) begin
				st_d = ST_CLK_UP;
				cnt_d = CLK_CYC[15:0];
			end
		end
		ST_CLK_UP: begin
			if (cnt_q == 16'h0000) begin
				st_d = ST_ACTIVE;
				mode_d = `PMSR_M_ACTIVE;
				woke_ev = 1'b1;
			end
		end
		default: begin
			st_d = ST_ACTIVE;
			mode_d = `PMSR_M_ACTIVE;
		end
	endcase
end

always @(posedge sys_clk_i or posedge rst_i) begin
	if (rst_i) begin
		st_q <= ST_ACTIVE;
		mode_q <= `PMSR_M_ACTIVE;
		cnt_q <= 16'h0000;
	end else begin
		st_q <= st_d;
		mode_q <= mode_d;
		cnt_q <= cnt_d;
	end
end

////////////////////////////////////////////////////////////////
// clock and power outputs
wire deep = (mode_q == `PMSR_M_HIBERNATE) || (mode_q == `PMSR_M_SHUTDOWN);
wire pwr_off = (st_q == ST_SLEEP) || (st_q == ST_DOWN && cnt_q == 16'h0000);
wire shut = (mode_q == `PMSR_M_SHUTDOWN);

// core clock gated in core-gated mode
assign core_clk_en_o = (st_q == ST_ACTIVE);
assign core_run_o = (st_q == ST_ACTIVE);
assign dma_clk_en_o = (st_q == ST_ACTIVE) || (st_q == ST_CGATED);
assign periph_clk_en_o = dma_clk_en_o;
assign digital_pwr_en_o = !(deep && pwr_off);
assign analog_pwr_en_o = !(deep && pwr_off);
assign logic_retain_o = deep && !shut && (st_q != ST_ACTIVE);
// pins held in both; config hibernate only
assign pin_out_hold_o = deep && (st_q != ST_ACTIVE) && (st_q != ST_CGATED);
assign pin_cfg_retain_o = pin_out_hold_o && !shut;
assign pri_rtc_pwr_en_o = !(deep && pwr_off) || wake_en_q[`PMSR_W_PRI_RTC];
assign sec_rtc_pwr_en_o = !(deep && pwr_off) ||
	(!shut && wake_en_q[`PMSR_W_SEC_RTC]);

////////////////////////////////////////////////////////////////
// sram configuration
wire instr_en = sram_cfg_q[`PMSR_C_INSTR_EN];
wire cache_en = sram_cfg_q[`PMSR_C_CACHE_EN];
wire [7:0] ret_kb;

// optional instruction 16 KB, data 8 KB
// banks: 0 data fixed, 1 data extra, 2-3 instruction halves
assign sram_ret_bank_o = shut ? 4'h0 : {ret_cfg_q[`PMSR_R_INSTR16],
	ret_cfg_q[`PMSR_R_INSTR16], ret_cfg_q[`PMSR_R_DATA8], 1'b1};
// 8 to 32 KB in 8 KB steps
assign ret_kb = `PMSR_RET_STEP_KB +
	(ret_cfg_q[`PMSR_R_DATA8] ? `PMSR_RET_STEP_KB : 8'h00) +
	(ret_cfg_q[`PMSR_R_INSTR16] ? `PMSR_RET_INSTR_KB : 8'h00);
assign sram_ret_kb_o = shut ? 8'h00 : ret_kb;
// instruction bank maps as data when off
assign data_sram_kb_o = instr_en ? `PMSR_BANK_KB : (`PMSR_BANK_KB + `PMSR_BANK_KB);
// cache takes 4 KB of instruction space
assign instr_sram_kb_o = !instr_en ? 8'h00 :
	(cache_en ? (`PMSR_BANK_KB - `PMSR_CACHE_KB) : `PMSR_BANK_KB);
assign cache_alloc_o = instr_en && cache_en;
// two parity bits per word when set
assign parity_en_o = sram_cfg_q[`PMSR_C_PARITY_EN];
assign sram_wait_o = 2'h0;
assign access_size_mask_o = 3'h7;

assign mode_o = mode_q;
assign irq_o = |(status_q & mask_q);

////////////////////////////////////////////////////////////////
// read port, data one cycle later
always @(posedge sys_clk_i or posedge rst_i) begin
	if (rst_i) begin
		reg_rdata_o <= 8'h00;
	end else if (reg_rd_i) begin
		case (reg_addr_i)
			`PMSR_A_CTRL: reg_rdata_o <= {5'h00, req_mode_q, 1'b0};
			`PMSR_A_MODE: reg_rdata_o <= {3'h0, st_q, mode_q};
			`PMSR_A_WAKE_EN: reg_rdata_o <= wake_en_q;
			`PMSR_A_SRAM_CFG: reg_rdata_o <= sram_cfg_q;
			`PMSR_A_RET_CFG: reg_rdata_o <= ret_cfg_q;
			`PMSR_A_STATUS: reg_rdata_o <= status_q;
			`PMSR_A_MASK: reg_rdata_o <= mask_q;
			`PMSR_A_INFO: reg_rdata_o <= sram_ret_kb_o;
			default: reg_rdata_o <= 8'h00;
		endcase
	end else begin
		reg_rdata_o <= 8'h00;
	end
end

endmodule

// file: tb/pmsr_monitor.sv
`timescale 1ns/100ps
module pmsr_monitor (
	// clock and reset
	input wire sys_clk_i,
	input wire rst_i,
	// watched outputs
	input wire [1:0] mode_o,
	input wire core_clk_en_o,
	input wire core_run_o,
	input wire dma_clk_en_o,
	input wire digital_pwr_en_o,
	input wire analog_pwr_en_o,
	input wire pin_cfg_retain_o,
	input wire logic_retain_o,
	input wire [7:0] sram_ret_kb_o,
	input wire [3:0] sram_ret_bank_o,
	input wire [7:0] data_sram_kb_o,
	input wire [7:0] instr_sram_kb_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	gate_active_a: assert property (core_clk_en_o |-> mode_o == 2'h0)
		else $error("core clock on outside active");
	gated_clk_a: assert property (mode_o == 2'h1 |-> !core_clk_en_o && dma_clk_en_o)
		else $error("core-gated clocks wrong");
	gated_norun_a: assert property (mode_o == 2'h1 |-> !core_run_o)
		else $error("core runs while gated");
	shut_off_a: assert property ((mode_o == 2'h3 && !digital_pwr_en_o)
		|-> !analog_pwr_en_o && !pin_cfg_retain_o && sram_ret_kb_o == 8'h00)
		else $error("shutdown keeps something powered");
	ret_size_a: assert property (logic_retain_o |-> sram_ret_kb_o == 8'h08
		+ (sram_ret_bank_o[3] ? 8'h10 : 8'h00) + (sram_ret_bank_o[1] ? 8'h08 : 8'h00))
		else $error("retained size disagrees with banks");
	ret_fixed_a: assert property (logic_retain_o |-> sram_ret_bank_o[0] && mode_o == 2'h2)
		else $error("fixed data bank not retained");
	sram_map_a: assert property (data_sram_kb_o ==
		(instr_sram_kb_o == 8'h00 ? 8'h40 : 8'h20))
		else $error("data sram size wrong");
	// core must stay stopped for three cycles after power returns, then run within 40 cycles
	wake_seq_a: assert property ($rose(digital_pwr_en_o)
		|-> !core_run_o [*3] ##[1:40] core_run_o)
		else $error("wake sequence out of order");
endmodule

bind pmsr_top pmsr_monitor i_pmsr_monitor (.*);

// file: tb/pmsr_wake_model.sv
`timescale 1ns/100ps
module pmsr_wake_model (
	// clock, reset, bench requests
	input wire sys_clk_i,
	input wire rst_i,
	input wire [5:0] wake_req_i,
	input wire core_run_i,
	// wake lines, idle low
	output reg [5:0] wake_o
);
	reg run_q;
	// sources hold their level until the core runs again, like a real pending irq
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_o <= 6'h00;
			run_q <= 1'b1;
		end else begin
			run_q <= core_run_i;
			wake_o <= (core_run_i && !run_q) ? 6'h00 : (wake_o | wake_req_i);
		end
	end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	reg sys_clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg [3:0] reg_addr_i = 4'h0;
	reg [7:0] reg_wdata_i = 8'h00;
	reg reg_wr_i = 1'b0;
	reg reg_rd_i = 1'b0;
	reg core_sleep_i = 1'b0;
	reg sram_parity_err_i = 1'b0;
	reg [5:0] wreq = 6'h00;
	integer num_errors = 0;
	integer compares = 0;
	integer i;
	wire [7:0] reg_rdata_o, sram_ret_kb_o, data_sram_kb_o, instr_sram_kb_o;
	wire [3:0] sram_ret_bank_o;
	wire [2:0] ext_wake_irq_i, access_size_mask_o;
	wire [1:0] sram_wait_o, mode_o;
	wire serial_rx_wake_i, primary_rt_counter_i, secondary_rt_counter_i, core_clk_en_o;
	wire core_run_o, dma_clk_en_o, periph_clk_en_o, digital_pwr_en_o, analog_pwr_en_o;
	wire logic_retain_o, pin_out_hold_o, pin_cfg_retain_o, pri_rtc_pwr_en_o;
	wire sec_rtc_pwr_en_o, cache_alloc_o, parity_en_o, irq_o;

	pmsr_top i_pmsr_top (.*);
	pmsr_wake_model i_pmsr_wake_model (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.wake_req_i(wreq),
		.core_run_i(core_run_o),
		.wake_o({secondary_rt_counter_i, primary_rt_counter_i, serial_rx_wake_i, ext_wake_irq_i})
	);

	initial forever #50 sys_clk_i = ~sys_clk_i;

	////////////////////////////////////////////////////////////////
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask

	// requests start just after a rising edge; tasks end mid-cycle
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge sys_clk_i);
			reg_addr_i <= a;
			reg_wdata_i <= d;
			reg_wr_i <= 1'b1;
			@(posedge sys_clk_i);
			reg_wr_i <= 1'b0;
			@(negedge sys_clk_i);
		end
	endtask

	task rd(input [3:0] a, input [7:0] exp);
		begin
			@(posedge sys_clk_i);
			reg_addr_i <= a;
			reg_rd_i <= 1'b1;
			@(posedge sys_clk_i);
			reg_rd_i <= 1'b0;
			@(negedge sys_clk_i);
			chk(reg_rdata_o, exp);
		end
	endtask

	task pulse(input [5:0] w);
		begin
			@(posedge sys_clk_i);
			wreq <= w;
			@(posedge sys_clk_i);
			wreq <= 6'h00;
			@(negedge sys_clk_i);
		end
	endtask

	task enter(input [7:0] ctl);
		begin
			@(posedge sys_clk_i);
			core_sleep_i <= 1'b1;
			@(negedge sys_clk_i);
			wr(4'h0, ctl);
		end
	endtask

	// s=1 waits for the core to run, s=0 for power to drop
	task wait_sig(input s);
		integer k;
		begin
			for (k = 0; k < 60 && (s ? !core_run_o : digital_pwr_en_o); k = k + 1)
				@(negedge sys_clk_i);
			chk(s ? core_run_o : !digital_pwr_en_o, 8'h01);
			if (s) begin
				@(posedge sys_clk_i);
				core_sleep_i <= 1'b0;
				@(negedge sys_clk_i);
			end
		end
	endtask

	////////////////////////////////////////////////////////////////
	task t_reset;
		begin
			rd(4'h0, 8'h00);
			rd(4'h1, 8'h00);
			rd(4'h2, 8'h0F);
			rd(4'h3, 8'h01);
			rd(4'h4, 8'h00);
			rd(4'h7, 8'h08);
			rd(4'h8, 8'h00);
		end
	endtask

	task t_sram;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				wr(4'h3, i[7:0]);
				chk(data_sram_kb_o, i[0] ? 8'h20 : 8'h40);
				chk(instr_sram_kb_o, i[0] ? (i[1] ? 8'h1C : 8'h20) : 8'h00);
				chk(cache_alloc_o, i[0] & i[1]);
				chk(parity_en_o, i[2]);
				chk({sram_wait_o, access_size_mask_o}, 8'h07);
			end
			// one parity fault edge, then write-one clear
			@(posedge sys_clk_i);
			sram_parity_err_i <= 1'b1;
			@(posedge sys_clk_i);
			sram_parity_err_i <= 1'b0;
			repeat (4) @(negedge sys_clk_i);
			rd(4'h5, 8'h80);
			wr(4'h6, 8'h80);
			chk(irq_o, 8'h01);
			wr(4'h5, 8'h80);
			rd(4'h5, 8'h00);
			chk(irq_o, 8'h00);
		end
	endtask

	task t_gated;
		begin
			wr(4'h3, 8'h01);
			// a request for active mode changes nothing
			enter(8'h01);
			repeat (3) @(negedge sys_clk_i);
			chk({mode_o, core_clk_en_o, core_run_o}, 8'h03);
			enter(8'h03);
			repeat (3) @(negedge sys_clk_i);
			chk({mode_o, core_clk_en_o, core_run_o}, 8'h04);
			chk({dma_clk_en_o, periph_clk_en_o, digital_pwr_en_o}, 8'h07);
			rd(4'h0, 8'h02);
			rd(4'h1, 8'h05);
			// partition write refused while gated
			wr(4'h3, 8'h07);
			pulse(6'h20);
			wait_sig(1'b1);
			chk(mode_o, 8'h00);
			rd(4'h3, 8'h01);
		end
	endtask

	task t_hib;
		for (i = 0; i < 4; i = i + 1) begin
			wr(4'h4, i[7:0]);
			wr(4'h6, i != 0 ? 8'hFF : 8'h00);
			enter(8'h05);
			wait_sig(1'b0);
			chk(sram_ret_kb_o, 8'h08 + (i[0] ? 8'h10 : 8'h00) + (i[1] ? 8'h08 : 8'h00));
			chk(sram_ret_bank_o, {i[0], i[0], i[1], 1'b1});
			chk({logic_retain_o, pin_out_hold_o, pin_cfg_retain_o, analog_pwr_en_o}, 8'h0E);
			pulse(6'h01 << i);
			wait_sig(1'b1);
			rd(4'h5, 8'h40 | (8'h01 << i));
			chk(irq_o, i != 0);
			wr(4'h5, 8'hFF);
			chk(irq_o, 8'h00);
		end
	endtask

	task t_shut;
		for (i = 0; i < 2; i = i + 1) begin
			wr(4'h2, i != 0 ? 8'h01 : 8'h3F);
			wr(4'h4, 8'h03);
			wr(4'h3, 8'h07);
			enter(8'h07);
			wait_sig(1'b0);
			chk({pin_out_hold_o, pin_cfg_retain_o, logic_retain_o, analog_pwr_en_o}, 8'h08);
			chk(sram_ret_kb_o, 8'h00);
			chk({pri_rtc_pwr_en_o, sec_rtc_pwr_en_o}, i != 0 ? 8'h00 : 8'h02);
			// serial and secondary counter must not wake shutdown
			pulse(6'h28);
			repeat (40) @(negedge sys_clk_i);
			chk(mode_o, 8'h03);
			pulse(i != 0 ? 6'h01 : 6'h10);
			wait_sig(1'b1);
			rd(4'h3, 8'h01);
			rd(4'h4, 8'h00);
			rd(4'h6, 8'h00);
		end
	endtask

	////////////////////////////////////////////////////////////////
	task complete_run;
		begin
			$display("errors=%0d compares=%0d", num_errors, compares);
			if (num_errors == 0 && compares > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask

	initial begin
		#500000;
		num_errors = num_errors + 1;
		complete_run;
	end

	initial begin
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(negedge sys_clk_i);
		t_reset;
		t_sram;
		t_gated;
		t_hib;
		t_shut;
		complete_run;
	end
endmodule
